// ==== hdl/eeprom_pkg.sv ====
// Purpose: Shared constants for the two-wire serial EEPROM target core
// Assumes: 200 MHz system clock, link pins sampled into that domain
// Notes:   All timing counts derive from printed times and the clock rate
package eeprom_pkg;
  // ---------------------------------------------------------------------
  // Addressing
  // ---------------------------------------------------------------------
  localparam logic [3:0] DEV_TYPE_CODE   = 4'hA;  // Fixed upper nibble
  localparam int         PAGE_BITS       = 3;     // Eight bytes per page
  localparam int         BITS_PER_WORD   = 8;
  localparam logic [3:0] ACK_SLOT        = 4'h8;  // Ninth clock of a word
  localparam logic [7:0] MEM_RESET_VALUE = 8'hFF; // Erased contents
  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int WRITE_CYCLE_MS  = 5;
  localparam int WRITE_CYCLE_CYC =
    (WRITE_CYCLE_MS * 1000000) / (CLK_PERIOD_PS / 1000);  // Stays in 32 bits
  // Protocol phases of the target
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_DEVADR = 6'h02,
    ST_WORDAD = 6'h04,
    ST_WDATA  = 6'h08,
    ST_RDATA  = 6'h10,
    ST_BUSY   = 6'h20
  } phase_t;
endpackage

// ==== hdl/byte_buffer_if.sv ====
// Purpose: Valid/ready carrier for read bytes between fetch and shifter
// Assumes: Single clock domain
// Notes:   Producer modport feeds the two-entry buffer
`timescale 1ns/1ps
interface byte_buffer_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

// ==== hdl/byte_fifo2.sv ====
// Purpose: Two-entry valid/ready buffer in the read data path
// Assumes: One clock, synchronous active-high reset
// Notes:   Honest full and empty; drain side may stall
`timescale 1ns/1ps
module byte_fifo2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic flush_in,
  byte_buffer_if.sink   fill,
  byte_buffer_if.source drain
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] store_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  // Handshakes gate on honest full and empty
  assign fill.ready  = (count_r != (AW+1)'(DEPTH));
  assign drain.valid = (count_r != '0);
  assign drain.data  = store_r[rd_ptr_r];
  assign push        = fill.valid && fill.ready;
  assign pop         = drain.valid && drain.ready;

  // Storage writes
  always_ff @(posedge clk_in) begin
    if (push) begin
      store_r[wr_ptr_r] <= fill.data;
    end
  end

  // Pointers and occupancy; flush drops stale prefetch
  always_ff @(posedge clk_in) begin
    if (reset_in || flush_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==== hdl/serial_eeprom_target_core.sv ====
// Purpose: Two-wire serial EEPROM target, 1-Kbit or 2-Kbit array
// Assumes: Link pins asynchronous to clk_in, sampled by two flip-flops
// Notes:   Array held in flip-flops; programming time is a parameter
//
// Behaviour
// [R1] Sample on clock rise, drive on fall
// [R2] Data line only pulled low or released
// [R3] Strap bits select one of eight devices
// [R4] Strapless variant: controller sends zero select
// [R5] 1-Kbit: 16 pages, 7-bit word address
// [R6] 2-Kbit: 32 pages, 8-bit word address
// [R7] Protect high blocks all array programming
// [R8] Protect low allows normal reads and writes
// [R9] Address byte: 1010, select bits, direction
// [R10] Acknowledge each received byte on ninth clock
// [R11] Write increments low three bits, wraps page
// [R12] After stop, program; ignore bus meanwhile
// [R13] Protected writes acknowledged but change nothing
// [R14] Programming completes within 5 ms
`timescale 1ns/1ps
module serial_eeprom_target_core
  import eeprom_pkg::*;
#(
  parameter int ADDR_BITS  = 8,               // 7 for 1-Kbit, 8 for 2-Kbit
  parameter int PROG_CYCLES = WRITE_CYCLE_CYC
) (
  input  wire logic clk_in,
  input  wire logic reset_in,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_out,
  input  wire logic strap_select_bit2_in,
  input  wire logic strap_select_bit1_in,
  input  wire logic strap_select_bit0_in,
  input  wire logic write_protect_in,
  output logic      busy_out
);
  localparam int DEPTH = 1 << ADDR_BITS;
  localparam int PCW   = $clog2(PROG_CYCLES + 1);

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  logic [1:0] scl_sync_r, sda_sync_r, wp_sync_r;
  logic [2:0] strap_a_r, strap_b_r;
  logic       scl_q_r, sda_q_r;
  // Two flops per pin; stage two feeds logic, and a third flop on clock and data finds edges
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      wp_sync_r  <= 2'h0;
      strap_a_r  <= 3'h0;
      strap_b_r  <= 3'h0;
      scl_q_r    <= 1'b1;
      sda_q_r    <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      wp_sync_r  <= {wp_sync_r[0], write_protect_in};
      strap_a_r  <= {strap_select_bit2_in, strap_select_bit1_in,
                     strap_select_bit0_in};
      strap_b_r  <= strap_a_r;
      scl_q_r    <= scl_sync_r[1];
      sda_q_r    <= sda_sync_r[1];
    end
  end

  logic scl, sda, scl_rise, scl_fall, start_ev, stop_ev, protect;
  assign scl      = scl_sync_r[1];
  assign sda      = sda_sync_r[1];
  assign scl_rise = scl && !scl_q_r;
  assign scl_fall = !scl && scl_q_r;
  // Data edges while clock high mark frame limits
  assign start_ev = scl && scl_q_r && sda_q_r && !sda;
  assign stop_ev  = scl && scl_q_r && !sda_q_r && sda;
  // [R8] open pin low
  // Pull-down of the open pin is external; a low reads as unprotected
  assign protect  = wp_sync_r[1];

  // ---------------------------------------------------------------------
  // Protocol state
  // ---------------------------------------------------------------------
  phase_t               phase_r;
  logic [3:0]           bit_cnt_r;
  logic [7:0]           shift_r;
  logic                 ack_slot_r;   // Ninth clock in progress
  logic                 drive_ack_r;
  logic                 host_ack_r;
  logic [ADDR_BITS-1:0] addr_r;
  logic                 pending_r;    // Unprogrammed page data held
  logic                 wr_seen_r;
  logic [PCW-1:0]       prog_cnt_r;
  logic [7:0]           page_buf_r [1 << PAGE_BITS];
  logic [(1<<PAGE_BITS)-1:0] page_vld_r;
  logic [7:0]           mem_r [DEPTH];
  logic [7:0]           tx_r;
  logic                 tx_active_r;

  logic byte_done, dev_match, word_taken, ack_end;
  assign byte_done = scl_rise && (bit_cnt_r == 4'(BITS_PER_WORD - 1));
  // Ninth clock ends at the fall after its rise
  assign ack_end   = scl_fall && (bit_cnt_r == ACK_SLOT + 4'h1);
  // [R9] address byte
  // [R3] strap compare
  // [R4] strapless parts wire straps low, so select zero matches
  assign dev_match = ({shift_r[6:0], sda} >> 4) == 8'(DEV_TYPE_CODE) &&
                     shift_r[2:0] == strap_b_r;
  assign busy_out  = (phase_r == ST_BUSY);

  // Read byte path through the two-entry buffer
  byte_buffer_if fetch_if ();
  byte_buffer_if shift_if ();
  logic fetch_flush;
  assign fetch_flush     = start_ev || stop_ev;
  assign fetch_if.valid  = (phase_r == ST_RDATA) && !fetch_flush;
  assign fetch_if.data   = mem_r[addr_r];
  assign shift_if.ready  = (phase_r == ST_RDATA) && !tx_active_r &&
                           ack_end && (host_ack_r || !wr_seen_r);
  assign word_taken      = fetch_if.valid && fetch_if.ready;
  byte_fifo2 #(.WIDTH(8), .DEPTH(2)) u_read_buf (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .flush_in (fetch_flush),
    .fill     (fetch_if.sink),
    .drain    (shift_if.source)
  );

  // Bit counter and ninth-clock slot; [R1] sample on rising edge
  always_ff @(posedge clk_in) begin
    if (reset_in || start_ev || stop_ev) begin
      bit_cnt_r  <= 4'h0;
      ack_slot_r <= 1'b0;
    end else if (ack_end) begin
      bit_cnt_r  <= 4'h0;
      ack_slot_r <= 1'b0;
    end else if (scl_fall && bit_cnt_r == ACK_SLOT) begin
      ack_slot_r <= 1'b1;  // Ninth low phase: line may now be pulled
    end else if (scl_rise && bit_cnt_r < ACK_SLOT) begin
      shift_r   <= {shift_r[6:0], sda};
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end else if (scl_rise && ack_slot_r) begin
      host_ack_r <= !sda;
      bit_cnt_r  <= bit_cnt_r + 4'h1;
    end
  end

  // Main sequencer
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      phase_r     <= ST_IDLE;
      addr_r      <= '0;
      pending_r   <= 1'b0;
      wr_seen_r   <= 1'b0;
      prog_cnt_r  <= '0;
      page_vld_r  <= '0;
      drive_ack_r <= 1'b0;
      tx_active_r <= 1'b0;
      tx_r        <= 8'hFF;
    end else if (phase_r == ST_BUSY) begin
      // [R12] inputs ignored
      // [R14] bounded programming time
      if (prog_cnt_r == PCW'(PROG_CYCLES - 1)) begin
        phase_r    <= ST_IDLE;
        prog_cnt_r <= '0;
      end else begin
        prog_cnt_r <= prog_cnt_r + 1'b1;
      end
    end else if (stop_ev) begin
      drive_ack_r <= 1'b0;
      tx_active_r <= 1'b0;
      // [R13] protected: no programming cycle
      if (pending_r && !protect) begin
        phase_r <= ST_BUSY;
      end else begin
        phase_r <= ST_IDLE;
      end
      pending_r  <= 1'b0;
      if (protect) page_vld_r <= '0;
    end else if (start_ev) begin
      phase_r     <= ST_DEVADR;
      drive_ack_r <= 1'b0;
      tx_active_r <= 1'b0;
      pending_r   <= 1'b0;
      page_vld_r  <= '0;
    end else begin
      // [R1] drive on falling edge
      if (ack_end) begin
        drive_ack_r <= 1'b0;
      end
      if (scl_fall) begin
        if (shift_if.valid && shift_if.ready) begin
          tx_r        <= shift_if.data;
          tx_active_r <= 1'b1;
        end else if (tx_active_r && bit_cnt_r == ACK_SLOT) begin
          tx_active_r <= 1'b0;  // Leave the ninth clock to the controller
        end else if (tx_active_r) begin
          tx_r <= {tx_r[6:0], 1'b1};
        end
      end
      if (word_taken) begin
        addr_r <= addr_r + 1'b1;  // Reads roll over the whole array
      end
      case (phase_r)
        ST_DEVADR: begin
          if (byte_done) begin
            if (dev_match) begin
              // [R10] ack device address
              drive_ack_r <= 1'b1;
              phase_r     <= sda ? ST_RDATA : ST_WORDAD;
              wr_seen_r   <= 1'b0;
            end else begin
              phase_r <= ST_IDLE;
            end
          end
        end
        ST_WORDAD: begin
          if (byte_done) begin
            // [R5] [R6] word address width
            addr_r      <= ADDR_BITS'({shift_r[6:0], sda});
            drive_ack_r <= 1'b1;
            phase_r     <= ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (byte_done) begin
            // [R10] ack data byte
            // [R13] acked even when protected
            drive_ack_r <= 1'b1;
            page_buf_r[addr_r[PAGE_BITS-1:0]] <= {shift_r[6:0], sda};
            page_vld_r[addr_r[PAGE_BITS-1:0]] <= 1'b1;
            pending_r <= 1'b1;
            // [R11] page wrap increment
            addr_r[PAGE_BITS-1:0] <= addr_r[PAGE_BITS-1:0] + 1'b1;
          end
        end
        ST_RDATA: begin
          // Missing controller acknowledge ends the read
          if (ack_end && !host_ack_r && wr_seen_r) begin
            phase_r <= ST_IDLE;
          end
          if (ack_end) begin
            wr_seen_r <= 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // Array commit in the first cycle of programming
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < DEPTH; i++) mem_r[i] <= MEM_RESET_VALUE;
    end else if (phase_r == ST_BUSY && prog_cnt_r == '0) begin
      // [R7] protect blocks programming
      for (int j = 0; j < (1 << PAGE_BITS); j++) begin
        if (page_vld_r[j] && !protect) begin
          mem_r[{addr_r[ADDR_BITS-1:PAGE_BITS], PAGE_BITS'(j)}] <=
            page_buf_r[j];
        end
      end
    end
  end

  // [R2] open-drain output: low or released
  assign sda_out    = 1'b0;
  assign sda_oe_out = (drive_ack_r && ack_slot_r) ||
                      (tx_active_r && !tx_r[7]);

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  sequence s_busy_entry;
    stop_ev && pending_r && !protect && phase_r != ST_BUSY;
  endsequence
  a_pin_low_only: assert property (@(posedge clk_in) disable iff (reset_in)
    sda_oe_out |-> !sda_out)  // [R2]
    else $error("data line driven high");
  a_busy_silent: assert property (@(posedge clk_in) disable iff (reset_in)
    busy_out |-> !sda_oe_out)  // [R12]
    else $error("drive during programming");
  a_busy_start: assert property (@(posedge clk_in) disable iff (reset_in)
    s_busy_entry |=> busy_out)  // [R12]
    else $error("programming not started");
  a_protect_no_prog: assert property (@(posedge clk_in)  // [R13]
    disable iff (reset_in) (stop_ev && protect && !busy_out) |=> !busy_out)
    else $error("protected write programmed");
  a_ack_on_match: assert property (@(posedge clk_in) disable iff (reset_in)
    (phase_r == ST_DEVADR && byte_done && dev_match && !stop_ev
     && !start_ev) |=> drive_ack_r)  // [R10]
    else $error("address not acknowledged");
  a_no_ack_miss: assert property (@(posedge clk_in) disable iff (reset_in)
    (phase_r == ST_DEVADR && byte_done && !dev_match && !stop_ev
     && !start_ev) |=> phase_r == ST_IDLE)  // [R3]
    else $error("foreign address taken");
  a_page_wrap: assert property (@(posedge clk_in) disable iff (reset_in)
    (phase_r == ST_WDATA && byte_done && !stop_ev && !start_ev) |=>
    addr_r[ADDR_BITS-1:PAGE_BITS] == $past(addr_r[ADDR_BITS-1:PAGE_BITS]))
    // [R11]
    else $error("write crossed page");
  a_prog_bound: assert property (@(posedge clk_in) disable iff (reset_in)
    prog_cnt_r <= PCW'(PROG_CYCLES - 1))  // [R14]
    else $error("programming overran");
  a_protect_mem: assert property (@(posedge clk_in) disable iff (reset_in)
    (protect && $past(protect)) |=> mem_r[0] == $past(mem_r[0]))  // [R7]
    else $error("array changed under protect");
endmodule

// ==== test/two_wire_ctl.sv ====
// Purpose: Two-wire bus controller model for the EEPROM bench
// Assumes: Line pulled high outside; clock idles high between frames
// Notes:   Tasks are called from the testbench
`timescale 1ns/1ps
module two_wire_ctl
  import eeprom_pkg::*;
(
  output logic      scl_out,
  output logic      sda_low_out,
  input  wire logic sda_in
);
  logic in_frame;

  // Idle: clock high, line released
  initial begin
    scl_out     = 1'b1;
    sda_low_out = 1'b0;
    in_frame    = 1'b0;
  end

  // One 48 ns clock; data moves mid-low, read early and late in high
  task automatic put_bit(input logic b, output logic seen,
                         output logic stable);
    scl_out = 1'b0;
    #12 sda_low_out = ~b;
    #12 scl_out = 1'b1;
    #2 seen = sda_in;
    #21 stable = (sda_in === seen);
    #1;
  endtask

  // Clock only moves inside a frame, so a first start skips the dip
  task automatic send_start();
    if (in_frame) begin
      scl_out = 1'b0;
      #12 sda_low_out = 1'b0;
      #12 scl_out = 1'b1;
    end
    #12 sda_low_out = 1'b1;
    #12 in_frame = 1'b1;
  endtask

  task automatic send_stop();
    scl_out = 1'b0;
    #12 sda_low_out = 1'b1;
    #12 scl_out = 1'b1;
    #12 sda_low_out = 1'b0;
    #24 in_frame = 1'b0;
  endtask

  // Eight bits, first bit most significant, then the ninth for the ack
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s, st;
    for (int i = 7; i >= 0; i--) put_bit(d[i], s, st);
    put_bit(1'b1, s, st);
    ack = ~s;
  endtask

  task automatic dev_addr(input logic [2:0] sel, input logic rw,
                          output logic ack);
    wbyte({DEV_TYPE_CODE, sel, rw}, ack);
  endtask

  // Read one byte; ack it when more are wanted
  task automatic rbyte(input logic more, output logic [7:0] d,
                       output logic stable);
    logic s, st;
    stable = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, d[i], st);
      stable &= st;
    end
    put_bit(~more, s, st);
  endtask
endmodule

// ==== test/testbench.sv ====
// Purpose: Self-checking bench, a 2-Kbit and a 1-Kbit target on one bus
// Assumes: Controller model owns the clock line and pulls data low
// Notes:   Short programming time keeps the run brief
`timescale 1ns/1ps
module testbench;
  import eeprom_pkg::*;
  localparam int PROG = 400;
  logic       clk_in        = 1'b0;
  logic       reset_in      = 1'b1;
  logic       write_protect = 1'b0;
  logic [2:0] strap_sel     = 3'h5;
  logic       scl, ctl_low, oe_a, oe_b, drv_a, drv_b, busy_a, busy_b;
  wire        sda_line      = ~(oe_a | oe_b | ctl_low);
  int         bad_count     = 0;
  int         n_compared    = 0;

  always #2.5 clk_in = ~clk_in;

  two_wire_ctl u_two_wire_ctl (.scl_out(scl), .sda_low_out(ctl_low),
    .sda_in(sda_line));
  // 2-Kbit part with driven straps
  serial_eeprom_target_core #(.ADDR_BITS(8), .PROG_CYCLES(PROG))
    u_serial_eeprom_target_core (.clk_in(clk_in), .reset_in(reset_in),
    .scl_in(scl), .sda_in(sda_line), .sda_out(drv_a), .sda_oe_out(oe_a),
    .strap_select_bit2_in(strap_sel[2]),
    .strap_select_bit1_in(strap_sel[1]),
    .strap_select_bit0_in(strap_sel[0]),
    .write_protect_in(write_protect), .busy_out(busy_a));
  // Strapless 1-Kbit part: straps low
  serial_eeprom_target_core #(.ADDR_BITS(7), .PROG_CYCLES(PROG))
    u_serial_eeprom_target_core_1k (.clk_in(clk_in), .reset_in(reset_in),
    .scl_in(scl), .sda_in(sda_line), .sda_out(drv_b), .sda_oe_out(oe_b),
    .strap_select_bit2_in(1'b0), .strap_select_bit1_in(1'b0),
    .strap_select_bit0_in(1'b0),
    .write_protect_in(write_protect), .busy_out(busy_b));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Address-only write frame; no data so nothing is programmed
  task automatic poll(input logic [7:0] first, output logic ack);
    u_two_wire_ctl.send_start();
    u_two_wire_ctl.wbyte(first, ack);
    u_two_wire_ctl.send_stop();
  endtask

  task automatic wr(input logic [2:0] sel, input logic [7:0] adr,
                    input logic [7:0] d[$]);
    logic ack;
    u_two_wire_ctl.send_start();
    u_two_wire_ctl.dev_addr(sel, 1'b0, ack);
    chk("device ack", ack, 1);
    u_two_wire_ctl.wbyte(adr, ack);
    chk("word ack", ack, 1);
    foreach (d[i]) begin
      u_two_wire_ctl.wbyte(d[i], ack);
      chk("data ack", ack, 1);
    end
    u_two_wire_ctl.send_stop();
  endtask

  // Dummy write for the address, repeated start, sequential read
  task automatic rd(input logic [2:0] sel, input logic [7:0] adr,
                    input int n, output logic [7:0] q[$]);
    logic       ack, stable;
    logic [7:0] b;
    q = {};
    u_two_wire_ctl.send_start();
    u_two_wire_ctl.dev_addr(sel, 1'b0, ack);
    u_two_wire_ctl.wbyte(adr, ack);
    u_two_wire_ctl.send_start();
    u_two_wire_ctl.dev_addr(sel, 1'b1, ack);
    chk("read ack", ack, 1);
    for (int i = 0; i < n; i++) begin
      u_two_wire_ctl.rbyte(i < n - 1, b, stable);
      chk("bit held through high", stable, 1);
      q.push_back(b);
    end
    u_two_wire_ctl.send_stop();
  endtask

  // Bounded wait, never open-ended, for programming to finish
  task automatic idle();
    int k;
    k = 0;
    while ((busy_a | busy_b) !== 1'b0 && k < PROG + 10) begin
      @(posedge clk_in);
      k++;
    end
    chk("programming ends in time", k < PROG + 10, 1);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk("line released", oe_a | oe_b, 0);
    chk("drive value low", drv_a | drv_b, 0);
    chk("busy after reset", busy_a | busy_b, 0);
    $display("test reset done");
  endtask

  task automatic t_select();
    logic ack;
    for (int s = 0; s < 8; s++) begin
      poll({DEV_TYPE_CODE, s[2:0], 1'b0}, ack);
      chk("select ack", ack, s == 5 || s == 0);
    end
    poll({4'hB, 3'h5, 1'b0}, ack);
    chk("wrong type code", ack, 0);
    @(posedge clk_in);
    strap_sel <= 3'h2;
    poll({DEV_TYPE_CODE, 3'h2, 1'b0}, ack);
    chk("new strap ack", ack, 1);
    @(posedge clk_in);
    strap_sel <= 3'h5;
    $display("test select done");
  endtask

  // Ten bytes from offset 5: roll-over overwrites offsets 5 and 6
  task automatic t_page();
    logic [7:0] d[$], q[$], exp[8];
    logic       ack;
    exp = '{default: MEM_RESET_VALUE};
    for (int i = 0; i < 10; i++) begin
      d.push_back(8'h30 + i[7:0]);
      exp[(5 + i) % 8] = 8'h30 + i[7:0];
    end
    wr(3'h5, 8'h15, d);
    chk("busy after stop", busy_a, 1);
    poll({DEV_TYPE_CODE, 3'h5, 1'b0}, ack);
    chk("no ack while busy", ack, 0);
    idle();
    rd(3'h5, 8'h10, 8, q);
    foreach (q[i]) chk("page wrap", q[i], exp[i]);
    $display("test page done");
  endtask

  task automatic t_protect();
    logic [7:0] q[$];
    @(posedge clk_in);
    write_protect <= 1'b1;
    wr(3'h5, 8'h40, {8'hA5, 8'h5A}); // acks kept
    chk("no programming locked", busy_a, 0);
    idle();
    rd(3'h5, 8'h40, 2, q);
    chk("locked byte 0", q[0], MEM_RESET_VALUE);
    chk("locked byte 1", q[1], MEM_RESET_VALUE);
    @(posedge clk_in);
    write_protect <= 1'b0;
    $display("test protect done");
  endtask

  // Same word address 0x85 on both sizes
  task automatic t_sizes();
    logic [7:0] q[$], r[$];
    wr(3'h5, 8'h85, {8'h5A});
    idle();
    wr(3'h0, 8'h85, {8'hC3});
    idle();
    rd(3'h0, 8'h05, 1, q);
    chk("7-bit word address", q[0], 8'hC3);
    rd(3'h5, 8'h05, 1, q);
    rd(3'h5, 8'h85, 1, r);
    chk("8-bit low half", q[0], MEM_RESET_VALUE);
    chk("8-bit high half", r[0], 8'h5A);
    $display("test sizes done");
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    t_reset();
    t_select();
    t_page();
    t_protect();
    t_sizes();
    summarize();
  end

  // Watchdog: tests need well under 100 us
  initial begin
    #200000;
    bad_count++;
    $display("BAD watchdog expected finish seen hang");
    summarize();
  end
endmodule
